//--- bis_pkg.sv
// constants, register map and state type of the brake interlock sequencer
package bis_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_OUT_SELECT = 8'h00;
  localparam logic [7:0] ADDR_ON_WAIT = 8'h04;
  localparam logic [7:0] ADDR_WAIT_FLOW = 8'h08;
  localparam logic [7:0] ADDR_WAIT_SPEED = 8'h0C;
  localparam logic [7:0] ADDR_WAIT_TIME = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ==========================================================
  // reset values and setting ranges
  localparam logic [11:0] OUT_SELECT_RESET = 12'h000;
  localparam logic [15:0] ON_WAIT_RESET = 16'h0000;
  localparam logic [15:0] ON_WAIT_MIN = 16'hF830;
  localparam logic [15:0] ON_WAIT_MAX = 16'h07D0;
  localparam logic [15:0] WAIT_FLOW_RESET = 16'h0000;
  localparam logic [15:0] WAIT_FLOW_MAX = 16'h01F4;
  localparam logic [15:0] WAIT_SPEED_RESET = 16'h0064;
  localparam logic [15:0] WAIT_SPEED_MIN = 16'h000A;
  localparam logic [15:0] WAIT_SPEED_MAX = 16'h0064;
  localparam logic [15:0] WAIT_TIME_RESET = 16'h0032;
  localparam logic [15:0] WAIT_TIME_MIN = 16'h000A;
  localparam logic [15:0] WAIT_TIME_MAX = 16'h0064;
  localparam logic [15:0] WAIT_TIME_UNIT_MS = 16'h000A;
  // ==========================================================
  // output terminal function codes
  localparam logic [3:0] FN_POS_COMPLETE = 4'h0;
  localparam logic [3:0] FN_ROTATION = 4'h1;
  localparam logic [3:0] FN_READY = 4'h2;
  localparam logic [3:0] FN_TORQUE_LIMITED = 4'h3;
  localparam logic [3:0] FN_BRAKE = 4'h4;
  localparam logic [3:0] FN_ENC_INDEX = 4'h5;
  localparam logic [3:0] FN_OVERTRAVEL = 4'h6;
  localparam logic [3:0] FN_EXCITED = 4'h7;
  localparam logic [3:0] FN_HOMED = 4'h8;
  localparam logic [3:0] FN_TORQUE_DETECT = 4'h9;
  localparam int TERMINALS = 3;
  localparam int DIGIT_W = 4;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_DELAY, ST_ON, ST_HOLD_DELAY, ST_BRAKE_DELAY, ST_RUN_STOP
  } bis_state_t;
endpackage : bis_pkg

//--- bis_ms_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ps
module bis_ms_tick #(
  parameter int CYCLES = bis_pkg::CYCLES_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  typedef struct packed {
    logic [23:0] cnt;
    logic tick;
  } bis_tick_t;

  bis_tick_t s;
  bis_tick_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 24'(CYCLES - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : bis_ms_tick

//--- bis_brake_interlock_sequencer.sv
// brake interlock sequencer with terminal routing and axi4-lite settings
// Contract
// - the brake interlock output is low to release the holding brake and high to apply it.
// - after reset no terminal carries the brake interlock until a selector digit chooses it.
// - the terminal select setting holds three 4-bit digits, one per terminal, and code 4 routes the brake there.
// - each digit decodes codes 0 to 9 into the ten documented terminal functions.
// - with a zero servo-on waiting time and speed below the waiting speed the brake is applied in the same cycle the servo turns off.
// - a signed waiting time of -2000 to 2000 ms offsets motor power against the brake output.
// - an alarm removes motor power at once and ignores the waiting time.
// - after servo off or alarm in motion the brake applies once speed falls below the waiting speed (10 to 100 rpm, default 100).
// - it also applies when the brake waiting time (10 ms units, default 50) runs out, whichever comes first.
`timescale 1ns/1ps
module bis_brake_interlock_sequencer #(
  parameter int TICK_CYCLES = bis_pkg::CYCLES_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic servo_on_req,
  input wire logic alarm,
  input wire logic [15:0] motor_speed,
  input wire logic position_complete,
  input wire logic rotation_detect,
  input wire logic drive_ready,
  input wire logic torque_limited,
  input wire logic encoder_index,
  input wire logic overtravel,
  input wire logic homing_complete,
  input wire logic torque_detect,
  output logic motor_energize,
  output logic term_out_0_n,
  output logic term_out_1_n,
  output logic term_out_2_n
);
  // ==========================================================
  // state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [11:0] out_select;
    logic [15:0] on_wait;
    logic [15:0] wait_flow;
    logic [15:0] wait_speed;
    logic [15:0] wait_time;
    logic [15:0] lat_wait;
    logic [15:0] lat_speed;
    logic [15:0] lat_time_ms;
    logic [15:0] ms_cnt;
    bis_pkg::bis_state_t state;
    logic energize;
    logic brake_apply;
    logic [2:0] term_n;
  } bis_regs_t;

  bis_regs_t s;
  bis_regs_t next_s;
  logic ms_tick;

  bis_ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(ms_tick)
  );

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_u

  function automatic logic [15:0] clamp_s(input logic [15:0] v);
    return ($signed(v) < $signed(bis_pkg::ON_WAIT_MIN)) ? bis_pkg::ON_WAIT_MIN :
      (($signed(v) > $signed(bis_pkg::ON_WAIT_MAX)) ? bis_pkg::ON_WAIT_MAX : v);
  endfunction : clamp_s

  function automatic logic [15:0] magnitude(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction : magnitude

  // ==========================================================
  // next state
  always_comb begin
    logic [15:0] speed_mag;
    logic [15:0] wait_mag;
    logic [15:0] merged;
    logic off_evt;
    logic [9:0] fn;
    speed_mag = magnitude(motor_speed);
    wait_mag = magnitude(s.lat_wait);
    merged = '0;
    off_evt = alarm || !servo_on_req;
    fn = '0;
    next_s = s;

    // write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // new settings land at once; the sequencer latches them per event
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = bis_pkg::RESP_OKAY;
      case (s.waddr)
        bis_pkg::ADDR_OUT_SELECT: begin
          merged = merge({4'h0, s.out_select}, s.wdata, s.wstrb);
          next_s.out_select = merged[11:0];
        end
        bis_pkg::ADDR_ON_WAIT: begin
          next_s.on_wait = clamp_s(merge(s.on_wait, s.wdata, s.wstrb));
        end
        bis_pkg::ADDR_WAIT_FLOW: begin
          merged = merge(s.wait_flow, s.wdata, s.wstrb);
          next_s.wait_flow = (merged > bis_pkg::WAIT_FLOW_MAX) ? bis_pkg::WAIT_FLOW_MAX : merged;
        end
        bis_pkg::ADDR_WAIT_SPEED: begin
          next_s.wait_speed = clamp_u(merge(s.wait_speed, s.wdata, s.wstrb),
            bis_pkg::WAIT_SPEED_MIN, bis_pkg::WAIT_SPEED_MAX);
        end
        bis_pkg::ADDR_WAIT_TIME: begin
          next_s.wait_time = clamp_u(merge(s.wait_time, s.wdata, s.wstrb),
            bis_pkg::WAIT_TIME_MIN, bis_pkg::WAIT_TIME_MAX);
        end
        default: begin
          next_s.bresp = bis_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;

    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = bis_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bis_pkg::ADDR_OUT_SELECT: next_s.rdata = {20'h0_0000, s.out_select};
        bis_pkg::ADDR_ON_WAIT: next_s.rdata = {{16{s.on_wait[15]}}, s.on_wait};
        bis_pkg::ADDR_WAIT_FLOW: next_s.rdata = {16'h0000, s.wait_flow};
        bis_pkg::ADDR_WAIT_SPEED: next_s.rdata = {16'h0000, s.wait_speed};
        bis_pkg::ADDR_WAIT_TIME: next_s.rdata = {16'h0000, s.wait_time};
        bis_pkg::ADDR_STATUS: next_s.rdata = {16'h0000, s.ms_cnt[7:0], 3'h0, s.state, s.energize, s.brake_apply};
        default: begin
          next_s.rdata = '0;
          next_s.rresp = bis_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // ==========================================================
    // sequencer
    if (ms_tick && s.ms_cnt != 16'hFFFF) begin
      next_s.ms_cnt = s.ms_cnt + 16'h0001;
    end
    case (s.state)
      bis_pkg::ST_OFF: begin
        next_s.brake_apply = 1'b1;
        next_s.energize = 1'b0;
        if (!off_evt) begin
          // power first, brake released after the waiting time of either sign
          next_s.energize = 1'b1;
          next_s.lat_wait = s.on_wait;
          next_s.ms_cnt = '0;
          next_s.state = bis_pkg::ST_ON_DELAY;
        end
      end
      bis_pkg::ST_ON_DELAY: begin
        if (off_evt) begin
          next_s.energize = 1'b0;
          next_s.brake_apply = 1'b1;
          next_s.state = bis_pkg::ST_OFF;
        end else if (s.ms_cnt >= wait_mag) begin
          next_s.brake_apply = 1'b0;
          next_s.state = bis_pkg::ST_ON;
        end
      end
      bis_pkg::ST_ON: begin
        if (off_evt) begin
          next_s.lat_wait = s.on_wait;
          next_s.lat_speed = s.wait_speed;
          next_s.lat_time_ms = 16'(s.wait_time * bis_pkg::WAIT_TIME_UNIT_MS);
          next_s.ms_cnt = '0;
          if (speed_mag >= s.wait_speed) begin
            // moving: coast, brake waits for speed or time
            next_s.energize = 1'b0;
            next_s.state = bis_pkg::ST_RUN_STOP;
          end else if (alarm || s.on_wait == 16'h0000) begin
            next_s.energize = 1'b0;
            next_s.brake_apply = 1'b1;
            next_s.state = bis_pkg::ST_OFF;
          end else if (!s.on_wait[15]) begin
            next_s.brake_apply = 1'b1;
            next_s.state = bis_pkg::ST_HOLD_DELAY;
          end else begin
            next_s.energize = 1'b0;
            next_s.state = bis_pkg::ST_BRAKE_DELAY;
          end
        end
      end
      bis_pkg::ST_HOLD_DELAY: begin
        // motor keeps holding while the brake engages
        if (alarm || s.ms_cnt >= s.lat_wait) begin
          next_s.energize = 1'b0;
          next_s.state = bis_pkg::ST_OFF;
        end
      end
      bis_pkg::ST_BRAKE_DELAY: begin
        if (alarm || s.ms_cnt >= wait_mag) begin
          next_s.brake_apply = 1'b1;
          next_s.state = bis_pkg::ST_OFF;
        end
      end
      bis_pkg::ST_RUN_STOP: begin
        if (speed_mag < s.lat_speed || s.ms_cnt >= s.lat_time_ms) begin
          next_s.brake_apply = 1'b1;
          next_s.state = bis_pkg::ST_OFF;
        end
      end
      default: begin
        next_s.energize = 1'b0;
        next_s.brake_apply = 1'b1;
        next_s.state = bis_pkg::ST_OFF;
      end
    endcase

    // ==========================================================
    // terminal routing, built from next values so brake and pin move together
    fn[bis_pkg::FN_POS_COMPLETE] = position_complete;
    fn[bis_pkg::FN_ROTATION] = rotation_detect;
    fn[bis_pkg::FN_READY] = drive_ready;
    fn[bis_pkg::FN_TORQUE_LIMITED] = torque_limited;
    fn[bis_pkg::FN_BRAKE] = !next_s.brake_apply;
    fn[bis_pkg::FN_ENC_INDEX] = encoder_index;
    fn[bis_pkg::FN_OVERTRAVEL] = overtravel;
    fn[bis_pkg::FN_EXCITED] = next_s.energize;
    fn[bis_pkg::FN_HOMED] = homing_complete;
    fn[bis_pkg::FN_TORQUE_DETECT] = torque_detect;
    for (int i = 0; i < bis_pkg::TERMINALS; i++) begin
      // codes above nine leave the terminal off; brake appears only where code 4 sits
      if (next_s.out_select[i*bis_pkg::DIGIT_W +: bis_pkg::DIGIT_W] <= bis_pkg::FN_TORQUE_DETECT) begin
        next_s.term_n[i] = !fn[next_s.out_select[i*bis_pkg::DIGIT_W +: bis_pkg::DIGIT_W]];
      end else begin
        next_s.term_n[i] = 1'b1;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.state <= bis_pkg::ST_OFF;
      s.out_select <= bis_pkg::OUT_SELECT_RESET;
      s.on_wait <= bis_pkg::ON_WAIT_RESET;
      s.wait_flow <= bis_pkg::WAIT_FLOW_RESET;
      s.wait_speed <= bis_pkg::WAIT_SPEED_RESET;
      s.wait_time <= bis_pkg::WAIT_TIME_RESET;
      s.brake_apply <= 1'b1;
      s.term_n <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign motor_energize = s.energize;
  assign term_out_0_n = s.term_n[0];
  assign term_out_1_n = s.term_n[1];
  assign term_out_2_n = s.term_n[2];
endmodule : bis_brake_interlock_sequencer

//--- bis_chk.sv
// port assertions for the brake interlock sequencer
`timescale 1ns/1ps
module bis_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic servo_on_req,
  input wire logic alarm,
  input wire logic motor_energize
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus and sequencer relations
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  write_resp_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after both taken");
  bresp_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  alarm_cut_a: assert property (alarm && motor_energize |=> !motor_energize)
    else $error("motor still powered after alarm");
  energize_cause_a: assert property ($rose(motor_energize) |-> $past(servo_on_req) && !$past(alarm))
    else $error("motor powered without servo on request");
endmodule : bis_chk

//--- bis_brake_relay.sv
// behavioural brake relay and brake supply on one interlock terminal
`timescale 1ns/1ps
module bis_brake_relay #(
  parameter int PICK = 2
) (
  input wire logic aclk,
  input wire logic coil_n,
  output logic brake_free
);
  int cnt = 0;
  // ==========================================================
  // relay coil: pull-in takes time, drop-out is at once
  always @(posedge aclk) begin
    if (coil_n) begin
      cnt <= 0;
      brake_free <= 1'b0;
    end else if (cnt < PICK) begin
      cnt <= cnt + 1;
    end else begin
      brake_free <= 1'b1;
    end
  end
endmodule : bis_brake_relay

//--- bis_brake_interlock_sequencer_tb_top.sv
// testbench for the brake interlock sequencer
`timescale 1ns/1ps
module bis_brake_interlock_sequencer_tb_top;
  localparam logic [1:0] OK = bis_pkg::RESP_OKAY;
  localparam logic [1:0] ER = bis_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn, servo_on_req, alarm, motor_energize, brake_free, on;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, st;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic term_out_0_n, term_out_1_n, term_out_2_n;
  logic [15:0] motor_speed;
  logic [9:0] fn;
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0000_0064, 32'h0000_0032};
  int errors, tests_run;
  assign st = {term_out_2_n, term_out_1_n, term_out_0_n, motor_energize};
  always #20 aclk = ~aclk;
  bis_brake_interlock_sequencer #(.TICK_CYCLES(10)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .servo_on_req, .alarm, .motor_speed, .position_complete(fn[0]), .rotation_detect(fn[1]),
    .drive_ready(fn[2]), .torque_limited(fn[3]), .encoder_index(fn[5]), .overtravel(fn[6]),
    .homing_complete(fn[8]), .torque_detect(fn[9]), .motor_energize, .term_out_0_n, .term_out_1_n,
    .term_out_2_n);
  bis_brake_relay #(.PICK(2)) u_relay (.aclk, .coil_n(term_out_0_n), .brake_free);
  // ==========================================================
  // tasks
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc
  task automatic drv(input logic o, input logic a, input logic [15:0] s);
    @(posedge aclk);
    servo_on_req <= o;
    alarm <= a;
    motor_speed <= s;
  endtask : drv
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: a stalled slave is left to the watchdog
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    ck(32'(s_axi_bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    ck(s_axi_rdata, d);
    ck(32'(s_axi_rresp), 32'(r));
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // ==========================================================
  // tests
  initial begin
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {servo_on_req, alarm} = 2'b00;
    motor_speed = 16'h0000;
    fn = 10'h000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    ck(st, 4'hE);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), rv[i], OK);
    rd(8'h20, 32'h0, ER);
    wr(8'h40, 32'h0000_0001, ER);
    $display("done reset and map");
    wr(bis_pkg::ADDR_ON_WAIT, 32'h0000_F448, OK);
    rd(bis_pkg::ADDR_ON_WAIT, 32'hFFFF_F830, OK);
    wr(bis_pkg::ADDR_WAIT_SPEED, 32'h0000_0005, OK);
    rd(bis_pkg::ADDR_WAIT_SPEED, 32'h0000_000A, OK);
    wr(bis_pkg::ADDR_WAIT_SPEED, 32'h0000_0064, OK);
    wr(bis_pkg::ADDR_WAIT_TIME, 32'h0000_00C8, OK);
    rd(bis_pkg::ADDR_WAIT_TIME, 32'h0000_0064, OK);
    wr(bis_pkg::ADDR_WAIT_TIME, 32'h0000_000A, OK);
    wr(bis_pkg::ADDR_ON_WAIT, 32'h0000_0000, OK);
    $display("done clamping");
    // each code once, bit set and all other bits set
    for (int c = 0; c < 16; c++) begin
      wr(bis_pkg::ADDR_OUT_SELECT, 32'(c), OK);
      for (int k = 0; k < 2; k++) begin
        @(posedge aclk);
        fn <= k ? 10'(1 << c) : ~10'(1 << c);
        cyc(3);
        on = (c < 10 && c != 4 && c != 7 && k == 1);
        ck(st, {!fn[0], !fn[0], !on, 1'b0});
      end
    end
    $display("done decode");
    wr(bis_pkg::ADDR_OUT_SELECT, 32'h0000_0444, OK);
    drv(1'b1, 1'b0, 16'h0000);
    cyc(4);
    ck(st, 4'h1);
    drv(1'b0, 1'b0, 16'h0000);
    cyc(1);
    ck(st, 4'hE);
    $display("done zero wait");
    wr(bis_pkg::ADDR_ON_WAIT, 32'h0000_0014, OK);
    drv(1'b1, 1'b0, 16'h0000);
    cyc(2);
    ck(st, 4'hF);
    cyc(185);
    ck(st, 4'hF);
    cyc(30);
    ck(st, 4'h1);
    ck(32'(brake_free), 32'h1);
    drv(1'b0, 1'b0, 16'h0000);
    cyc(2);
    ck(st, 4'hF);
    cyc(185);
    ck(st, 4'hF);
    cyc(30);
    ck(st, 4'hE);
    drv(1'b1, 1'b0, 16'h0000);
    cyc(230);
    drv(1'b0, 1'b0, 16'h0000);
    cyc(2);
    ck(st, 4'hF);
    drv(1'b0, 1'b1, 16'h0000);
    cyc(1);
    ck(st, 4'hE);
    drv(1'b0, 1'b0, 16'h0000);
    $display("done positive wait and alarm");
    wr(bis_pkg::ADDR_ON_WAIT, 32'h0000_FFEC, OK);
    drv(1'b1, 1'b0, 16'h0000);
    cyc(230);
    ck(st, 4'h1);
    drv(1'b0, 1'b0, 16'h0000);
    cyc(1);
    ck(st, 4'h0);
    cyc(185);
    ck(st, 4'h0);
    cyc(30);
    ck(st, 4'hE);
    ck(32'(brake_free), 32'h0);
    $display("done negative wait");
    wr(bis_pkg::ADDR_ON_WAIT, 32'h0000_0000, OK);
    drv(1'b1, 1'b0, 16'h0000);
    cyc(4);
    drv(1'b0, 1'b0, 16'hFE0C);
    cyc(1);
    ck(st, 4'h0);
    cyc(20);
    ck(st, 4'h0);
    drv(1'b0, 1'b0, 16'hFFCE);
    cyc(3);
    ck(st, 4'hE);
    $display("done running speed");
    // timer must restart here, and the new limit waits for the next event
    drv(1'b1, 1'b0, 16'h0000);
    cyc(4);
    drv(1'b1, 1'b1, 16'h01F4);
    cyc(1);
    ck(st, 4'h0);
    wr(bis_pkg::ADDR_WAIT_TIME, 32'h0000_0064, OK);
    cyc(900);
    ck(st, 4'h0);
    cyc(130);
    ck(st, 4'hE);
    drv(1'b0, 1'b0, 16'h0000);
    $display("done running timeout");
    final_report();
  end
  // run takes about 2500 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report();
  end
endmodule : bis_brake_interlock_sequencer_tb_top

bind bis_brake_interlock_sequencer bis_chk u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .servo_on_req, .alarm, .motor_energize);
